// >>> ncd_transfer_decode.sv
// Transfer and pointer instruction decoder of the nibble core.
// Assumes program memory presents one word per instr_valid_i pulse and
// the data RAM answers a read combinationally from ram_addr_o.
`timescale 1ns/1ps
module ncd_transfer_decode (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic instr_valid_i,
  input wire logic [8:0] instr_i,
  input wire logic [3:0] ram_rdata_i,
  output logic [5:0] ram_addr_o,
  output logic [3:0] ram_wdata_o,
  output logic ram_we_o,
  output logic [3:0] acc_o,
  output logic [3:0] b_o,
  output logic [1:0] x_o,
  output logic [3:0] y_o,
  output logic [7:0] ext_o,
  output logic [2:0] page_reg_o,
  output logic carry_flag_o,
  output logic skip_pending_o,
  output logic skipped_o,
  output logic other_o,
  output logic sw_valid_o,
  output logic sw_error_o,
  output logic [2:0] sw_kind_o,
  output logic [6:0] sw_addr_o,
  output logic [2:0] sw_page_o,
  output logic [3:0] sw_imm_o
);
  ncd_pkg::ncd_state_e state_reg, state_next;
  ncd_pkg::ncd_sw_kind_e kind_reg, kind_next;
  logic sw_drop_reg, sw_drop_next;
  logic [3:0] acc_reg, acc_next;
  logic [3:0] b_reg, b_next;
  logic [1:0] x_reg, x_next;
  logic [3:0] y_reg, y_next;
  logic [7:0] ext_reg, ext_next;
  logic [2:0] page_reg, page_next;
  logic carry_flag_reg;
  logic skip_reg, skip_next;
  logic lxy_prev_reg, lxy_prev_next;
  logic skipped_reg, skipped_next;
  logic other_reg, other_next;
  logic sw_valid_reg, sw_valid_next;
  logic sw_error_reg, sw_error_next;
  logic [2:0] sw_kind_reg, sw_kind_next;
  logic [6:0] sw_addr_reg, sw_addr_next;
  logic [2:0] sw_page_reg, sw_page_next;
  logic [3:0] sw_imm_reg, sw_imm_next;

  logic [4:0] group;
  logic [3:0] low;
  logic is_lxy;
  logic is_mem;
  logic [1:0] mem_form;
  logic step_dec;
  logic [3:0] y_stepped;
  logic y_wrap;
  logic sw_ok;
  logic [6:0] sw_addr;
  logic [2:0] sw_page;
  logic [3:0] sw_imm;
  ncd_pkg::ncd_sw_kind_e first_kind;
  logic exec;

  assign group = instr_i[8:ncd_pkg::GROUP_LSB];
  assign low = instr_i[3:0];
  assign is_lxy = (instr_i[8:6] == ncd_pkg::LXY_TOP);
  assign is_mem = (group == ncd_pkg::GRP_MEM);
  assign mem_form = low[3:2];
  // Pointer follows X and Y immediately, so a change redirects the next access
  assign ram_addr_o = {x_reg, y_reg};
  assign ram_wdata_o = acc_reg;

  // Which second word the current first word announces
  always_comb begin
    first_kind = ncd_pkg::NCD_SW_NONE;
    if (group == ncd_pkg::GRP_FAR_JUMP ||
        instr_i == ncd_pkg::OP_FAR_JUMP_LO) begin
      first_kind = ncd_pkg::NCD_SW_FAR_JUMP;
    end else if (group == ncd_pkg::GRP_FAR_CALL) begin
      first_kind = ncd_pkg::NCD_SW_FAR_CALL;
    end else if (instr_i == ncd_pkg::OP_PAGED_FAR_JUMP) begin
      first_kind = ncd_pkg::NCD_SW_PAGED_JUMP;
    end else if (instr_i == ncd_pkg::OP_PAGED_FAR_CALL) begin
      first_kind = ncd_pkg::NCD_SW_PAGED_CALL;
    end else if (instr_i == ncd_pkg::OP_COMPARE_IMM) begin
      first_kind = ncd_pkg::NCD_SW_COMPARE;
    end else if (instr_i == ncd_pkg::OP_DIGIT_TEST) begin
      first_kind = ncd_pkg::NCD_SW_DIGIT;
    end
  end

  assign step_dec = is_mem ? (mem_form == ncd_pkg::MEM_EXCH_DEC)
                           : (instr_i == ncd_pkg::OP_DEC_Y);

  ncd_y_step u_y_step (
    .y_i(y_reg),
    .dec_i(step_dec),
    .y_o(y_stepped),
    .wrap_o(y_wrap)
  );

  ncd_second_word u_second_word (
    .kind_i(kind_reg),
    .word_i(instr_i),
    .ok_o(sw_ok),
    .addr_o(sw_addr),
    .page_o(sw_page),
    .imm_o(sw_imm)
  );

  // A first word executes unless a skip or a pointer-immediate run blocks it
  assign exec = instr_valid_i && (state_reg == ncd_pkg::NCD_ST_FIRST) &&
                !skip_reg && !(is_lxy && lxy_prev_reg);

  // The write strobe must follow exec exactly, so skipped exchanges stay out
  always_comb begin
    ram_we_o = 1'b0;
    if (exec && is_mem && mem_form != ncd_pkg::MEM_LOAD) begin
      ram_we_o = 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    sw_drop_next = sw_drop_reg;
    acc_next = acc_reg;
    b_next = b_reg;
    x_next = x_reg;
    y_next = y_reg;
    ext_next = ext_reg;
    page_next = page_reg;
    skip_next = skip_reg;
    lxy_prev_next = lxy_prev_reg;
    skipped_next = 1'b0;
    other_next = 1'b0;
    sw_valid_next = 1'b0;
    sw_error_next = 1'b0;
    sw_kind_next = sw_kind_reg;
    sw_addr_next = sw_addr_reg;
    sw_page_next = sw_page_reg;
    sw_imm_next = sw_imm_reg;
    if (instr_valid_i) begin
      case (state_reg)
        ncd_pkg::NCD_ST_FIRST: begin
          lxy_prev_next = is_lxy;
          if (first_kind != ncd_pkg::NCD_SW_NONE) begin
            // A skipped two-word instruction loses its operand too
            state_next = ncd_pkg::NCD_ST_SECOND;
            kind_next = first_kind;
            sw_drop_next = skip_reg;
          end
          if (skip_reg || (is_lxy && lxy_prev_reg)) begin
            skipped_next = 1'b1;
            skip_next = 1'b0;
          end else if (is_lxy) begin
            x_next = instr_i[5:4];
            y_next = low;
          end else if (is_mem) begin
            acc_next = ram_rdata_i;
            x_next = x_reg ^ low[1:0];
            if (mem_form == ncd_pkg::MEM_EXCH_DEC ||
                mem_form == ncd_pkg::MEM_EXCH_INC) begin
              y_next = y_stepped;
              skip_next = y_wrap;
            end
          end else begin
            case (instr_i)
              ncd_pkg::OP_COPY_B_TO_ACC: acc_next = b_reg;
              ncd_pkg::OP_COPY_ACC_TO_B: b_next = acc_reg;
              ncd_pkg::OP_COPY_Y_TO_ACC: acc_next = y_reg;
              ncd_pkg::OP_COPY_ACC_TO_Y: y_next = acc_reg;
              ncd_pkg::OP_LOAD_EXT: ext_next = {b_reg, acc_reg};
              ncd_pkg::OP_READ_EXT: begin
                b_next = ext_reg[7:4];
                acc_next = ext_reg[3:0];
              end
              // Accumulator bit 3 has no place in the page register
              ncd_pkg::OP_LOAD_PAGE: page_next = acc_reg[2:0];
              ncd_pkg::OP_INC_Y, ncd_pkg::OP_DEC_Y: begin
                y_next = y_stepped;
                skip_next = y_wrap;
              end
              default: begin
                // Two-word firsts wait for the operand before handing off
                other_next = (first_kind == ncd_pkg::NCD_SW_NONE);
              end
            endcase
          end
        end
        ncd_pkg::NCD_ST_SECOND: begin
          state_next = ncd_pkg::NCD_ST_FIRST;
          lxy_prev_next = 1'b0;
          if (sw_drop_reg) begin
            skipped_next = 1'b1;
          end else begin
            sw_valid_next = sw_ok;
            sw_error_next = !sw_ok;
            sw_kind_next = kind_reg;
            sw_addr_next = sw_addr;
            sw_page_next = sw_page;
            sw_imm_next = sw_imm;
          end
        end
        default: begin
          state_next = ncd_pkg::NCD_ST_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ncd_pkg::NCD_ST_FIRST;
      kind_reg <= ncd_pkg::NCD_SW_NONE;
      sw_drop_reg <= 1'b0;
      acc_reg <= 4'h0;
      b_reg <= 4'h0;
      x_reg <= 2'h0;
      y_reg <= 4'h0;
      ext_reg <= 8'h00;
      page_reg <= 3'h0;
      carry_flag_reg <= 1'b0;
      skip_reg <= 1'b0;
      lxy_prev_reg <= 1'b0;
      skipped_reg <= 1'b0;
      other_reg <= 1'b0;
      sw_valid_reg <= 1'b0;
      sw_error_reg <= 1'b0;
      sw_kind_reg <= 3'h0;
      sw_addr_reg <= 7'h00;
      sw_page_reg <= 3'h0;
      sw_imm_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      sw_drop_reg <= sw_drop_next;
      acc_reg <= acc_next;
      b_reg <= b_next;
      x_reg <= x_next;
      y_reg <= y_next;
      ext_reg <= ext_next;
      page_reg <= page_next;
      // No transfer here touches the carry flag
      carry_flag_reg <= carry_flag_reg;
      skip_reg <= skip_next;
      lxy_prev_reg <= lxy_prev_next;
      skipped_reg <= skipped_next;
      other_reg <= other_next;
      sw_valid_reg <= sw_valid_next;
      sw_error_reg <= sw_error_next;
      sw_kind_reg <= sw_kind_next;
      sw_addr_reg <= sw_addr_next;
      sw_page_reg <= sw_page_next;
      sw_imm_reg <= sw_imm_next;
    end
  end

  assign acc_o = acc_reg;
  assign b_o = b_reg;
  assign x_o = x_reg;
  assign y_o = y_reg;
  assign ext_o = ext_reg;
  assign page_reg_o = page_reg;
  assign carry_flag_o = carry_flag_reg;
  assign skip_pending_o = skip_reg;
  assign skipped_o = skipped_reg;
  assign other_o = other_reg;
  assign sw_valid_o = sw_valid_reg;
  assign sw_error_o = sw_error_reg;
  assign sw_kind_o = sw_kind_reg;
  assign sw_addr_o = sw_addr_reg;
  assign sw_page_o = sw_page_reg;
  assign sw_imm_o = sw_imm_reg;
endmodule

// >>> ncd_pkg.sv
// Constants, opcodes and enumerations of the nibble core transfer decoder.
// Assumes 9-bit instruction words and a 4-bit data path.
package ncd_pkg;
  localparam int unsigned WORD_W = 9;
  localparam int unsigned GROUP_LSB = 4;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned X_W = 2;
  localparam int unsigned E_W = 8;
  localparam int unsigned PAGE_W = 3;
  localparam int unsigned ADDR_W = 7;

  // First words, full nine bits
  localparam logic [8:0] OP_COPY_B_TO_ACC = 9'h01E;
  localparam logic [8:0] OP_COPY_ACC_TO_B = 9'h00E;
  localparam logic [8:0] OP_COPY_Y_TO_ACC = 9'h01F;
  localparam logic [8:0] OP_COPY_ACC_TO_Y = 9'h00C;
  localparam logic [8:0] OP_LOAD_EXT = 9'h01A;
  localparam logic [8:0] OP_READ_EXT = 9'h02A;
  localparam logic [8:0] OP_LOAD_PAGE = 9'h029;
  localparam logic [8:0] OP_INC_Y = 9'h013;
  localparam logic [8:0] OP_DEC_Y = 9'h017;
  localparam logic [8:0] OP_FAR_JUMP_LO = 9'h001;
  localparam logic [8:0] OP_PAGED_FAR_JUMP = 9'h010;
  localparam logic [8:0] OP_PAGED_FAR_CALL = 9'h050;
  localparam logic [8:0] OP_COMPARE_IMM = 9'h025;
  localparam logic [8:0] OP_DIGIT_TEST = 9'h024;
  // Five-bit groups
  localparam logic [4:0] GRP_FAR_JUMP = 5'h03;
  localparam logic [4:0] GRP_FAR_CALL = 5'h07;
  localparam logic [4:0] GRP_MEM = 5'h06;
  // Pointer immediate: top three bits 011
  localparam logic [2:0] LXY_TOP = 3'h3;
  // Memory group: low nibble bits 3:2 select the form
  localparam logic [1:0] MEM_EXCH = 2'h0;
  localparam logic [1:0] MEM_LOAD = 2'h1;
  localparam logic [1:0] MEM_EXCH_INC = 2'h2;
  localparam logic [1:0] MEM_EXCH_DEC = 2'h3;

  // Second-word formats
  localparam logic [1:0] SW_JUMP_TOP = 2'h3;
  localparam logic [1:0] SW_CALL_TOP = 2'h2;
  localparam logic [4:0] SW_COMPARE_TOP = 5'h0B;
  localparam logic [8:0] SW_DIGIT_TEST = 9'h02B;

  localparam logic [3:0] Y_MAX = 4'hF;
  localparam logic [3:0] Y_ZERO = 4'h0;

  typedef enum logic [2:0] {
    NCD_SW_NONE,
    NCD_SW_FAR_JUMP,
    NCD_SW_FAR_CALL,
    NCD_SW_PAGED_JUMP,
    NCD_SW_PAGED_CALL,
    NCD_SW_COMPARE,
    NCD_SW_DIGIT
  } ncd_sw_kind_e;

  typedef enum logic {
    NCD_ST_FIRST,
    NCD_ST_SECOND
  } ncd_state_e;
endpackage

// >>> ncd_y_step.sv
// Four-bit Y pointer stepper with wrap detection.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module ncd_y_step (
  input wire logic [3:0] y_i,
  input wire logic dec_i,
  output logic [3:0] y_o,
  output logic wrap_o
);
  always_comb begin
    if (dec_i) begin
      y_o = y_i - 4'h1;
      wrap_o = (y_o == ncd_pkg::Y_MAX);
    end else begin
      y_o = y_i + 4'h1;
      wrap_o = (y_o == ncd_pkg::Y_ZERO);
    end
  end
endmodule

// >>> ncd_second_word.sv
// Second-word format checker and field extractor.
// Combinational; the kind comes from the first word already seen.
`timescale 1ns/1ps
module ncd_second_word (
  input wire ncd_pkg::ncd_sw_kind_e kind_i,
  input wire logic [8:0] word_i,
  output logic ok_o,
  output logic [6:0] addr_o,
  output logic [2:0] page_o,
  output logic [3:0] imm_o
);
  always_comb begin
    addr_o = word_i[6:0];
    page_o = word_i[2:0];
    imm_o = word_i[3:0];
    case (kind_i)
      ncd_pkg::NCD_SW_FAR_JUMP:
        ok_o = (word_i[8:7] == ncd_pkg::SW_JUMP_TOP);
      ncd_pkg::NCD_SW_FAR_CALL:
        ok_o = (word_i[8:7] == ncd_pkg::SW_CALL_TOP);
      ncd_pkg::NCD_SW_PAGED_JUMP:
        ok_o = (word_i[8:7] == ncd_pkg::SW_JUMP_TOP) && !word_i[3];
      ncd_pkg::NCD_SW_PAGED_CALL:
        ok_o = (word_i[8:7] == ncd_pkg::SW_CALL_TOP) && !word_i[3];
      ncd_pkg::NCD_SW_COMPARE:
        ok_o = (word_i[8:4] == ncd_pkg::SW_COMPARE_TOP);
      ncd_pkg::NCD_SW_DIGIT:
        ok_o = (word_i == ncd_pkg::SW_DIGIT_TEST);
      default:
        ok_o = 1'b0;
    endcase
    // Paged forms carry only the high address bits; the low part is 0ppp
    if (kind_i == ncd_pkg::NCD_SW_PAGED_JUMP ||
        kind_i == ncd_pkg::NCD_SW_PAGED_CALL) begin
      addr_o = {word_i[6:4], 4'h0};
    end
  end
endmodule

// >>> ncd_transfer_decode_checker.sv
// Port-level checks of the transfer decoder.
// Bound to ncd_transfer_decode; one clock, synchronous reset.
`timescale 1ns/1ps
module ncd_transfer_decode_checker (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic instr_valid_i,
  input wire logic [8:0] instr_i,
  input wire logic [3:0] ram_rdata_i,
  input wire logic [5:0] ram_addr_o,
  input wire logic [3:0] ram_wdata_o,
  input wire logic ram_we_o,
  input wire logic [3:0] acc_o,
  input wire logic [1:0] x_o,
  input wire logic [3:0] y_o,
  input wire logic carry_flag_o,
  input wire logic skip_pending_o,
  input wire logic skipped_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic run_ok;
  logic load_pointer_immediate;
  assign run_ok = instr_valid_i && !skip_pending_o;
  assign load_pointer_immediate = instr_valid_i && instr_i[8:6] == 3'h3;
  a_carry_untouched: assert property (!carry_flag_o)
    else $error("carry flag moved");
  a_pointer_forms: assert property (ram_addr_o == {x_o, y_o})
    else $error("data pointer not x and y");
  a_write_cause: assert property (ram_we_o |-> run_ok
    && instr_i[8:4] == 5'h06 && instr_i[3:2] != 2'h1 && ram_wdata_o == acc_o)
    else $error("unexpected ram write");
  a_mem_group: assert property (run_ok && instr_i[8:4] == 5'h06 |=>
    acc_o == $past(ram_rdata_i) && x_o == ($past(x_o) ^ $past(instr_i[1:0])))
    else $error("memory form result wrong");
  a_inc_wrap: assert property (run_ok && instr_i == 9'h013
    && y_o == 4'hF |=> y_o == 4'h0 && skip_pending_o)
    else $error("increment wrap wrong");
  a_dec_wrap: assert property (run_ok && instr_i == 9'h017
    && y_o == 4'h0 |=> y_o == 4'hF && skip_pending_o)
    else $error("decrement wrap wrong");
  a_skip_drops: assert property (skip_pending_o && instr_valid_i |=>
    skipped_o && $stable(acc_o) && $stable(x_o) && $stable(y_o))
    else $error("skipped word executed");
  a_lxy_run: assert property (load_pointer_immediate ##1 load_pointer_immediate |=> skipped_o && $stable(y_o))
    else $error("second pointer load executed");
  c_exchange: cover property (ram_we_o);
  c_skip: cover property (skipped_o);
  c_lxy_pair: cover property (load_pointer_immediate ##1 load_pointer_immediate);
endmodule

// >>> ncd_prog_mem.sv
// Program memory model: hands queued words over, one a cycle, with stalls.
// Assumes the bench queues words through push_i in program order.
`timescale 1ns/1ps
module ncd_prog_mem (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic push_i,
  input wire logic [8:0] word_i,
  input wire logic stall_i,
  output logic instr_valid_o,
  output logic [8:0] instr_o
);
  logic [8:0] fifo[$];
  initial begin
    instr_valid_o = 1'b0;
    instr_o = 9'h000;
  end
  always @(posedge clk_i) begin
    if (push_i) fifo.push_back(word_i);
    if (!sys_rst_i && !stall_i && fifo.size() > 0) begin
      instr_valid_o <= 1'b1;
      instr_o <= fifo.pop_front();
    end else begin
      instr_valid_o <= 1'b0;
      // Idle bus inverts its word each cycle, so the last word shows again on every second idle cycle
      instr_o <= ~instr_o;
    end
  end
endmodule

// >>> tb.sv
// Self-checking bench of the transfer decoder against a reference model.
// Assumes ncd_prog_mem feeds words; the data RAM is modelled here.
`timescale 1ns/1ps
module tb;
  localparam logic [8:0] OPS [12] = '{9'h01E, 9'h00E, 9'h01F, 9'h00C,
    9'h01A, 9'h02A, 9'h029, 9'h013, 9'h017, 9'h010, 9'h050, 9'h025};
  logic clk_i = 1'b0, sys_rst_i = 1'b1, push = 1'b0, stall = 1'b0;
  logic [8:0] word = 9'h000, instr;
  logic valid, took = 1'b0, we, carry, skp, skipped, other, swv, swe;
  logic [3:0] ram [64], mram [64], rdata, wdata, acc, b, y, imm;
  logic [5:0] addr;
  logic [1:0] x, m_x = 2'h0;
  logic [7:0] ext, m_ext = 8'h00;
  logic [2:0] page, kind, m_pg = 3'h0, m_k = 3'h0;
  logic [6:0] swaddr;
  logic [2:0] swpage;
  logic [3:0] m_acc = 4'h0, m_b = 4'h0, m_y = 4'h0;
  logic m_skip = 1'b0, m_run = 1'b0, m_sw = 1'b0, m_dsw = 1'b0;
  logic [46:0] exp_q[$];
  int num_errors = 0, n_compared = 0;

  ncd_prog_mem ncd_prog_mem_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .push_i(push), .word_i(word), .stall_i(stall),
    .instr_valid_o(valid), .instr_o(instr));
  ncd_transfer_decode ncd_transfer_decode_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .instr_valid_i(valid), .instr_i(instr),
    .ram_rdata_i(rdata), .ram_addr_o(addr), .ram_wdata_o(wdata),
    .ram_we_o(we), .acc_o(acc), .b_o(b), .x_o(x), .y_o(y), .ext_o(ext),
    .page_reg_o(page), .carry_flag_o(carry), .skip_pending_o(skp),
    .skipped_o(skipped), .other_o(other), .sw_valid_o(swv),
    .sw_error_o(swe), .sw_kind_o(kind), .sw_addr_o(swaddr),
    .sw_page_o(swpage), .sw_imm_o(imm));

  initial forever #2 clk_i = ~clk_i;
  assign rdata = ram[addr];
  always @(posedge clk_i) if (we) ram[addr] <= wdata;

  function automatic logic [2:0] kind_of(input logic [8:0] w);
    if (w[8:4] == 5'h03 || w == 9'h001) return 3'h1;
    if (w[8:4] == 5'h07) return 3'h2;
    if (w == 9'h010) return 3'h3;
    if (w == 9'h050) return 3'h4;
    if (w == 9'h025) return 3'h5;
    return (w == 9'h024) ? 3'h6 : 3'h0;
  endfunction

  function automatic logic [8:0] second(input logic [2:0] k,
                                        input logic [8:0] r);
    case (k)
      3'h1: return {2'b11, r[6:0]};
      3'h2: return {2'b10, r[6:0]};
      3'h3: return {2'b11, r[6:4], 1'b0, r[2:0]};
      3'h4: return {2'b10, r[6:4], 1'b0, r[2:0]};
      3'h5: return {5'h0B, r[3:0]};
      default: return 9'h02B;
    endcase
  endfunction

  // Defined codes are drawn, plus undefined 0Bx words that raise other_o
  function automatic logic [8:0] pick(input logic [31:0] r);
    int s;
    s = r[12:8] % 21;
    if (s < 12) return OPS[s];
    if (s < 14) return {3'h3, r[5:0]};
    if (s < 17) return {5'h06, r[3:0]};
    if (s == 17) return {5'h03, r[3:0]};
    if (s == 18) return {5'h07, r[3:0]};
    if (s == 19) return r[0] ? 9'h001 : 9'h024;
    // A one-word code outside this block must raise other_o
    return {5'h0B, r[3:0]};
  endfunction

  task automatic step(input logic [8:0] w);
    logic drop;
    logic sv;
    logic [3:0] t;
    logic oth;
    logic [6:0] sa;
    drop = 1'b0;
    sv = 1'b0;
    oth = 1'b0;
    if (m_sw) begin
      m_sw = 1'b0;
      drop = m_dsw;
      sv = !m_dsw;
    end else begin
      drop = m_skip || (w[8:6] == 3'h3 && m_run);
      m_run = (w[8:6] == 3'h3);
      m_k = kind_of(w);
      m_sw = (m_k != 3'h0);
      m_dsw = drop;
      m_skip = 1'b0;
      if (!drop) begin
        t = mram[{m_x, m_y}];
        case (w)
          9'h01E: m_acc = m_b;
          9'h00E: m_b = m_acc;
          9'h01F: m_acc = m_y;
          9'h00C: m_y = m_acc;
          9'h01A: m_ext = {m_b, m_acc};
          9'h02A: {m_b, m_acc} = m_ext;
          9'h029: m_pg = m_acc[2:0];
          9'h013: begin m_y++; m_skip = (m_y == 4'h0); end
          9'h017: begin m_y--; m_skip = (m_y == 4'hF); end
          default: oth = (m_k == 3'h0) && w[8:6] != 3'h3 && w[8:4] != 5'h06;
        endcase
        if (w[8:6] == 3'h3) {m_x, m_y} = w[5:0];
        if (w[8:4] == 5'h06) begin
          if (w[3:2] != 2'h1) mram[{m_x, m_y}] = m_acc;
          m_acc = t;
          m_x = m_x ^ w[1:0];
          if (w[3:2] == 2'h2) begin m_y++; m_skip = (m_y == 4'h0); end
          if (w[3:2] == 2'h3) begin m_y--; m_skip = (m_y == 4'hF); end
        end
      end
    end
    // Paged forms carry only the high address bits
    sa = (m_k == 3'h3 || m_k == 3'h4) ? {w[6:4], 4'h0} : w[6:0];
    exp_q.push_back({m_acc, m_b, m_x, m_y, m_ext, m_pg, 1'b0, drop, sv,
      sv ? m_k : 3'h0, (sv && m_k == 3'h5) ? w[3:0] : 4'h0, oth, 1'b0,
      sv ? {sa, w[2:0]} : 10'h000});
  endtask

  task automatic send(input logic [8:0] w);
    @(posedge clk_i);
    push <= 1'b1;
    word <= w;
    stall <= ($urandom % 4) == 0;
    step(w);
  endtask

  task automatic prog(input logic [8:0] w);
    logic [2:0] k;
    k = kind_of(w);
    send(w);
    if (k != 3'h0) send(second(k, 9'($urandom)));
  endtask

  task automatic check(input logic [46:0] seen, input logic [46:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk_i) took <= valid && !sys_rst_i;
  always @(negedge clk_i) begin
    logic [46:0] seen, want;
    if (took && exp_q.size() > 0) begin
      want = exp_q.pop_front();
      seen = {acc, b, x, y, ext, page, carry, skipped, swv,
        swv ? kind : 3'h0, (swv && kind == 3'h5) ? imm : 4'h0, other, swe,
        swv ? {swaddr, swpage} : 10'h000};
      check(seen[46:22], want[46:22]);
      check(seen[21:0], want[21:0]);
    end
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    num_errors++;
    close_out();
  end

  initial begin
    void'($urandom(32'h73c10978));
    for (int i = 0; i < 64; i++) begin
      ram[i] = 4'(i) ^ 4'h5;
      mram[i] = ram[i];
    end
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    prog(9'h0FF);
    prog(9'h0C0);
    prog(9'h013);
    prog(9'h025);
    prog(9'h06B);
    prog(9'h0B5);
    prog(9'h010);
    repeat (1500) prog(pick($urandom));
    @(posedge clk_i);
    push <= 1'b0;
    stall <= 1'b0;
    for (int i = 0; i < 20000 && exp_q.size() > 0; i++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    if (exp_q.size() != 0) num_errors++;
    close_out();
  end
endmodule

bind ncd_transfer_decode ncd_transfer_decode_checker
  ncd_transfer_decode_checker_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .ram_rdata_i(ram_rdata_i), .ram_addr_o(ram_addr_o),
  .ram_wdata_o(ram_wdata_o), .ram_we_o(ram_we_o), .acc_o(acc_o),
  .x_o(x_o), .y_o(y_o), .carry_flag_o(carry_flag_o),
  .skip_pending_o(skip_pending_o), .skipped_o(skipped_o));
